// File: hdl/tilt_pkg.sv
// Shared constants for the tilt PWM compass readout.
// Assumes one 200 MHz system clock; all times are derived to cycles here.
package tilt_pkg;
   localparam int CLK_HZ = 200000000;
   // Accelerometer PWM: 100 Hz, 50 percent at level, 30..70 percent at full tilt
   localparam int PWM_HZ = 100;
   localparam int PERIOD_CYC = CLK_HZ / PWM_HZ;
   localparam int PERIOD_TOL_PCT = 10;
   localparam int PERIOD_MIN_CYC = PERIOD_CYC / 100 * (100 - PERIOD_TOL_PCT);
   localparam int PERIOD_MAX_CYC = PERIOD_CYC / 100 * (100 + PERIOD_TOL_PCT);
   localparam int DUTY_MID_PCT = 50;
   localparam int DUTY_HI_PCT = 70;
   localparam int LUT_MAX = 90;
   localparam int LUT_ENTRIES = LUT_MAX + 1;
   // Index = |2*high - period| * SCALE / period, which is |g| * 90
   localparam int SCALE = LUT_MAX * 100 / (2 * (DUTY_HI_PCT - DUTY_MID_PCT));
   localparam int CNT_W = 23;
   localparam int DEG_W = 7;
   localparam int QUO_W = 8;
   localparam int NUM_W = 32;
   // Snapshot power window: 10 ms every 1000 ms
   localparam int SNAP_MS = 10;
   localparam int FRAME_MS = 1000;
   localparam int SNAP_CYC = CLK_HZ / 1000 * SNAP_MS;
   localparam int FRAME_CYC = CLK_HZ / 1000 * FRAME_MS;
   localparam int FRAME_W = 28;
   // Automatic strap toggle interval
   localparam int STRAP_S = 10;
   localparam int STRAP_CYC = CLK_HZ * STRAP_S;
   localparam int STRAP_W = 32;
   // Digitized channels
   localparam int ADC_W = 10;
   localparam int AXIS_W = 12;
   localparam logic [1:0] CH_REF = 2'h0;
   localparam logic [1:0] CH_X = 2'h1;
   localparam logic [1:0] CH_Y = 2'h2;
   localparam logic [1:0] CH_Z = 2'h3;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DIV   = 2'b01,
      ST_LOOK  = 2'b10,
      ST_STORE = 2'b11
   } calc_state_t;
endpackage

// File: hdl/tilt_rom_if.sv
// Lookup port between the tilt calculator and the angle table.
// Assumes the table answers one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
interface tilt_rom_if;
   logic [tilt_pkg::DEG_W-1:0] addr;
   logic [tilt_pkg::DEG_W-1:0] deg;
   modport requester (output addr, input deg);
   modport table_side (input addr, output deg);
endinterface
`default_nettype wire

// File: hdl/tilt_angle_rom.sv
// 91-entry table from gravity magnitude (in 1/90 g) to degrees.
// Assumes a registered read: data follow the address by one clock.
`timescale 1ns/1ps
`default_nettype none
module tilt_angle_rom (
   input wire logic clk,
   input wire logic rst_b,
   tilt_rom_if.table_side rom
);
   // Smallest degree whose sine reaches i/90, using an integer sine estimate
   function automatic int asin_deg(input int i);
      int d;
      int p;
      int found;
      found = tilt_pkg::LUT_MAX;
      for (d = tilt_pkg::LUT_MAX; d >= 0; d--) begin
         p = d * (180 - d);
         if (360 * p >= i * (40500 - p)) begin
            found = d;
         end
      end
      return found;
   endfunction

   logic [tilt_pkg::DEG_W-1:0] table_w [tilt_pkg::LUT_ENTRIES];
   logic [tilt_pkg::DEG_W-1:0] deg_q;

   for (genvar i = 0; i < tilt_pkg::LUT_ENTRIES; i++) begin : g_entry
      assign table_w[i] = tilt_pkg::DEG_W'(asin_deg(i));
   end

   // Address is clamped by the requester, so it never leaves the table
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         deg_q <= '0;
      end else begin
         deg_q <= table_w[rom.addr];
      end
   end

   assign rom.deg = deg_q;
endmodule
`default_nettype wire

// File: hdl/tilt_pwm_compass_readout.sv
// Compass readout: tilt PWM duty measurement, magnetic axis correction,
// strap toggle scheduling and low-power measurement snapshots.
// Assumes PWM pins are asynchronous; ADC results and user inputs share clk.
`timescale 1ns/1ps
`default_nettype none
module tilt_pwm_compass_readout #(
   parameter int PERIOD_MIN = tilt_pkg::PERIOD_MIN_CYC,
   parameter int PERIOD_MAX = tilt_pkg::PERIOD_MAX_CYC,
   parameter int SNAP_CYCLES = tilt_pkg::SNAP_CYC,
   parameter int FRAME_CYCLES = tilt_pkg::FRAME_CYC,
   parameter int STRAP_CYCLES = tilt_pkg::STRAP_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tilt_x_pwm,
   input wire logic tilt_y_pwm,
   input wire logic adc_valid,
   input wire logic [1:0] adc_channel,
   input wire logic [tilt_pkg::ADC_W-1:0] adc_data,
   input wire logic signed [tilt_pkg::AXIS_W-1:0] corr_x,
   input wire logic signed [tilt_pkg::AXIS_W-1:0] corr_y,
   input wire logic signed [tilt_pkg::AXIS_W-1:0] corr_z,
   input wire logic low_power_en,
   input wire logic auto_strap_en,
   input wire logic strap_request,
   output logic strap_line,
   output logic sensor_power,
   output logic meas_done,
   output logic [1:0] tilt_valid,
   output logic signed [7:0] pitch_deg,
   output logic signed [7:0] roll_deg,
   output logic [tilt_pkg::ADC_W-1:0] ref_level,
   output logic signed [tilt_pkg::AXIS_W-1:0] axis_x,
   output logic signed [tilt_pkg::AXIS_W-1:0] axis_y,
   output logic signed [tilt_pkg::AXIS_W-1:0] axis_z
);
   localparam int CW = tilt_pkg::CNT_W;
   localparam int NW = tilt_pkg::NUM_W;

   tilt_rom_if rom_bus ();
   tilt_angle_rom u_rom (
      .clk(clk),
      .rst_b(rst_b),
      .rom(rom_bus.table_side)
   );

   // ---------------- Duty measurement, one copy per tilt axis
   wire [1:0] pwm_pin = {tilt_y_pwm, tilt_x_pwm};
   logic [1:0][CW-1:0] per_w;
   logic [1:0][CW-1:0] high_w;
   logic [1:0] evt_w;
   logic [1:0] valid_w;

   for (genvar a = 0; a < 2; a++) begin : g_axis
      logic [1:0] sync_q;
      logic prev_q;
      logic seen_q;
      logic valid_q;
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] hi_tmp_q;
      logic [CW-1:0] per_q;
      logic [CW-1:0] high_q;
      wire rise = sync_q[1] & ~prev_q;
      wire fall = ~sync_q[1] & prev_q;
      wire in_win = (cnt_q >= CW'(PERIOD_MIN)) && (cnt_q <= CW'(PERIOD_MAX));
      wire good = rise & seen_q & in_win;
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            sync_q <= '0;
            prev_q <= 1'b0;
            seen_q <= 1'b0;
            valid_q <= 1'b0;
            cnt_q <= '0;
            hi_tmp_q <= '0;
            per_q <= '0;
            high_q <= '0;
         end else begin
            sync_q <= {sync_q[0], pwm_pin[a]};
            prev_q <= sync_q[1];
            if (rise) begin
               cnt_q <= CW'(1);
               seen_q <= 1'b1;
               valid_q <= good;
            end else if (cnt_q != {CW{1'b1}}) begin
               cnt_q <= cnt_q + CW'(1);
            end
            if (fall) begin
               hi_tmp_q <= cnt_q;
            end
            if (good) begin
               per_q <= cnt_q;
               high_q <= hi_tmp_q;
            end
         end
      end
      assign per_w[a] = per_q;
      assign high_w[a] = high_q;
      assign evt_w[a] = good;
      assign valid_w[a] = valid_q;
   end

   // ---------------- Duty to signed degrees
   tilt_pkg::calc_state_t state_q;
   logic [1:0] pend_q;
   logic sel_q;
   logic sign_q;
   logic [NW-1:0] rem_q;
   logic [CW-1:0] den_q;
   logic [2:0] bit_q;
   logic [tilt_pkg::QUO_W-1:0] quo_q;
   logic [1:0] tilt_got_q;
   logic signed [7:0] pitch_q;
   logic signed [7:0] roll_q;

   // X is served first; a Y result waits at most one calculation
   wire sel_w = ~pend_q[0];
   wire [CW:0] twice_w = {high_w[sel_w], 1'b0};
   wire [CW:0] per_ext_w = {1'b0, per_w[sel_w]};
   wire up_w = twice_w >= per_ext_w;
   wire [CW:0] diff_w = up_w ? twice_w - per_ext_w : per_ext_w - twice_w;
   wire [NW-1:0] num_w = NW'(diff_w) * NW'(tilt_pkg::SCALE);
   wire [NW-1:0] trial_w = NW'(den_q) << bit_q;
   wire fits_w = rem_q >= trial_w;
   wire over_w = quo_q > tilt_pkg::QUO_W'(tilt_pkg::LUT_MAX);
   wire start_w = (state_q == tilt_pkg::ST_IDLE) && (pend_q != 2'b00);
   wire store_w = state_q == tilt_pkg::ST_STORE;
   wire [1:0] clr_w = start_w ? {sel_w, ~sel_w} : 2'b00;
   wire signed [7:0] mag_w = {1'b0, rom_bus.deg};
   wire signed [7:0] deg_w = sign_q ? mag_w : -mag_w;

   assign rom_bus.addr = over_w ? tilt_pkg::DEG_W'(tilt_pkg::LUT_MAX) : quo_q[tilt_pkg::DEG_W-1:0];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= tilt_pkg::ST_IDLE;
         pend_q <= 2'b00;
         sel_q <= 1'b0;
         sign_q <= 1'b0;
         rem_q <= '0;
         den_q <= '0;
         bit_q <= 3'h0;
         quo_q <= '0;
         pitch_q <= '0;
         roll_q <= '0;
      end else begin
         pend_q <= (pend_q & ~clr_w) | evt_w;
         unique case (state_q)
            tilt_pkg::ST_IDLE: begin
               if (start_w) begin
                  sel_q <= sel_w;
                  sign_q <= up_w;
                  rem_q <= num_w;
                  den_q <= per_w[sel_w];
                  bit_q <= 3'h7;
                  quo_q <= '0;
                  state_q <= tilt_pkg::ST_DIV;
               end
            end
            tilt_pkg::ST_DIV: begin
               // Quotient never exceeds SCALE since high time cannot pass the period
               if (fits_w) begin
                  rem_q <= rem_q - trial_w;
                  quo_q[bit_q] <= 1'b1;
               end
               if (bit_q == 3'h0) begin
                  state_q <= tilt_pkg::ST_LOOK;
               end else begin
                  bit_q <= bit_q - 3'h1;
               end
            end
            tilt_pkg::ST_LOOK: begin
               state_q <= tilt_pkg::ST_STORE;
            end
            tilt_pkg::ST_STORE: begin
               if (sel_q) begin
                  roll_q <= deg_w;
               end else begin
                  pitch_q <= deg_w;
               end
               state_q <= tilt_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------- Snapshot timing and magnetic channels
   logic [tilt_pkg::FRAME_W-1:0] frame_q;
   logic power_q;
   logic [3:0] adc_got_q;
   logic done_sent_q;
   logic done_q;
   logic [tilt_pkg::ADC_W-1:0] ref_q;
   logic [2:0][tilt_pkg::ADC_W-1:0] raw_q;
   logic [tilt_pkg::AXIS_W-1:0] axis_q [3];

   wire frame_end_w = frame_q == tilt_pkg::FRAME_W'(FRAME_CYCLES - 1);
   wire snap_start_w = frame_q == '0;
   wire power_d = ~low_power_en | (frame_q < tilt_pkg::FRAME_W'(SNAP_CYCLES));
   wire [3:0] adc_hit_w = adc_valid ? (4'h1 << adc_channel) : 4'h0;
   wire [1:0] tilt_hit_w = store_w ? {sel_q, ~sel_q} : 2'b00;
   wire all_got_w = (&adc_got_q) & (&tilt_got_q);
   wire signed [tilt_pkg::AXIS_W-1:0] ref_s_w = {2'b00, ref_q};
   wire [2:0][tilt_pkg::AXIS_W-1:0] corr_w = {corr_z, corr_y, corr_x};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_q <= '0;
         power_q <= 1'b0;
         adc_got_q <= 4'h0;
         tilt_got_q <= 2'b00;
         done_sent_q <= 1'b0;
         done_q <= 1'b0;
         ref_q <= '0;
         raw_q <= '0;
      end else begin
         frame_q <= frame_end_w ? '0 : frame_q + tilt_pkg::FRAME_W'(1);
         power_q <= power_d;
         // New captures in the restart cycle still count
         adc_got_q <= (snap_start_w ? 4'h0 : adc_got_q) | adc_hit_w;
         tilt_got_q <= (snap_start_w ? 2'b00 : tilt_got_q) | tilt_hit_w;
         done_q <= all_got_w & ~done_sent_q & ~snap_start_w;
         if (snap_start_w) begin
            done_sent_q <= 1'b0;
         end else if (all_got_w) begin
            done_sent_q <= 1'b1;
         end
         if (adc_valid && adc_channel == tilt_pkg::CH_REF) begin
            ref_q <= adc_data;
         end
         if (adc_valid && adc_channel != tilt_pkg::CH_REF) begin
            raw_q[adc_channel - 2'h1] <= adc_data;
         end
      end
   end

   for (genvar c = 0; c < 3; c++) begin : g_mag
      wire signed [tilt_pkg::AXIS_W-1:0] raw_s = {2'b00, raw_q[c]};
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            axis_q[c] <= '0;
         end else begin
            axis_q[c] <= raw_s - $signed(corr_w[c]) - ref_s_w;
         end
      end
   end

   // ---------------- Strap scheduling
   logic [tilt_pkg::STRAP_W-1:0] strap_cnt_q;
   logic strap_q;
   wire strap_tick_w = auto_strap_en && (strap_cnt_q == tilt_pkg::STRAP_W'(STRAP_CYCLES - 1));
   wire strap_fire_w = strap_tick_w | strap_request;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_cnt_q <= '0;
         strap_q <= 1'b0;
      end else begin
         // A user request also restarts the automatic interval
         if (strap_fire_w || !auto_strap_en) begin
            strap_cnt_q <= '0;
         end else begin
            strap_cnt_q <= strap_cnt_q + tilt_pkg::STRAP_W'(1);
         end
         if (strap_fire_w) begin
            strap_q <= ~strap_q;
         end
      end
   end

   assign strap_line = strap_q;
   assign sensor_power = power_q;
   assign meas_done = done_q;
   assign tilt_valid = valid_w;
   assign pitch_deg = pitch_q;
   assign roll_deg = roll_q;
   assign ref_level = ref_q;
   assign axis_x = axis_q[0];
   assign axis_y = axis_q[1];
   assign axis_z = axis_q[2];
endmodule
`default_nettype wire

// File: test/readout_sva.sv
// Checker for the compass readout, bound to its top module.
// Assumes one clock and the sim-sized counts handed down by the bind.
`timescale 1ns/1ps
`default_nettype none
module readout_sva #(
   parameter int SNAP_CYCLES = 20,
   parameter int FRAME_CYCLES = 200,
   parameter int STRAP_CYCLES = 50
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic adc_valid,
   input wire logic [1:0] adc_channel,
   input wire logic [tilt_pkg::ADC_W-1:0] adc_data,
   input wire logic signed [tilt_pkg::AXIS_W-1:0] corr_x,
   input wire logic low_power_en,
   input wire logic auto_strap_en,
   input wire logic strap_request,
   input wire logic strap_line,
   input wire logic sensor_power,
   input wire logic meas_done,
   input wire logic [1:0] tilt_valid,
   input wire logic signed [7:0] pitch_deg,
   input wire logic signed [7:0] roll_deg,
   input wire logic [tilt_pkg::ADC_W-1:0] ref_level,
   input wire logic signed [tilt_pkg::AXIS_W-1:0] axis_x
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Long spans are counted here, too long to unroll in a property
   logic [31:0] gap_q;
   logic [31:0] on_q;
   logic [31:0] off_q;
   logic strap_last_q;
   logic lp_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_q <= '0;
         on_q <= '0;
         off_q <= '0;
         strap_last_q <= 1'b0;
         lp_q <= 1'b0;
      end else begin
         gap_q <= (!auto_strap_en || strap_line != strap_last_q) ? '0 : gap_q + 1;
         // The cycle that turns gating on still shows the ungated power level
         on_q <= (low_power_en && lp_q && sensor_power) ? on_q + 1 : '0;
         off_q <= (low_power_en && !sensor_power) ? off_q + 1 : '0;
         strap_last_q <= strap_line;
         lp_q <= low_power_en;
      end
   end
   property p_req_toggle;
      strap_request |=> strap_line != $past(strap_line);
   endproperty
   a_req_toggle: assert property (p_req_toggle) else $error("strap line ignored a request");
   property p_strap_quiet;
      !strap_request && !auto_strap_en |=> $stable(strap_line);
   endproperty
   a_strap_quiet: assert property (p_strap_quiet) else $error("strap line moved unasked");
   property p_auto_gap;
      auto_strap_en |-> gap_q <= STRAP_CYCLES + 2;
   endproperty
   a_auto_gap: assert property (p_auto_gap) else $error("automatic strap toggle overdue");
   property p_power_full;
      !low_power_en |=> sensor_power;
   endproperty
   a_power_full: assert property (p_power_full) else $error("sensor power dropped");
   property p_snap_on;
      on_q <= SNAP_CYCLES && off_q <= FRAME_CYCLES - SNAP_CYCLES;
   endproperty
   a_snap_on: assert property (p_snap_on) else $error("snapshot window length wrong");
   property p_done_pulse;
      meas_done |=> !meas_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
   property p_x_hold;
      !tilt_valid[0] |=> $stable(pitch_deg);
   endproperty
   a_x_hold: assert property (p_x_hold) else $error("pitch moved while invalid");
   property p_y_hold;
      !tilt_valid[1] |=> $stable(roll_deg);
   endproperty
   a_y_hold: assert property (p_y_hold) else $error("roll moved while invalid");
   property p_ref;
      adc_valid && adc_channel == tilt_pkg::CH_REF |=> ref_level == $past(adc_data);
   endproperty
   a_ref: assert property (p_ref) else $error("reference count not taken");
   property p_axis_x;
      adc_valid && adc_channel == tilt_pkg::CH_X |=> ##1
         axis_x == $signed({2'b00, $past(adc_data, 2)}) - $past(corr_x) - $signed({2'b00, $past(ref_level)});
   endproperty
   a_axis_x: assert property (p_axis_x) else $error("x axis value wrong");
   c_done: cover property (meas_done);
   c_strap: cover property (strap_request ##1 strap_line);
   c_valid: cover property (tilt_valid == 2'b11);
endmodule
bind tilt_pwm_compass_readout readout_sva #(.SNAP_CYCLES(SNAP_CYCLES), .FRAME_CYCLES(FRAME_CYCLES),
   .STRAP_CYCLES(STRAP_CYCLES)) readout_sva_inst (.clk, .rst_b, .adc_valid, .adc_channel, .adc_data,
   .corr_x, .low_power_en, .auto_strap_en, .strap_request, .strap_line, .sensor_power, .meas_done,
   .tilt_valid, .pitch_deg, .roll_deg, .ref_level, .axis_x);
`default_nettype wire

// File: test/accel_pwm_model.sv
// Accelerometer stand-in: two free-running tilt PWM lines.
// Assumes period and high counts in clk cycles, set by the bench.
`timescale 1ns/1ps
`default_nettype none
module accel_pwm_model (
   input wire logic clk,
   input wire logic [15:0] per_x,
   input wire logic [15:0] hi_x,
   input wire logic [15:0] per_y,
   input wire logic [15:0] hi_y,
   output logic pwm_x,
   output logic pwm_y
);
   // Y starts out of phase so the two axes never line up
   logic [15:0] cx_q = 16'h0000;
   logic [15:0] cy_q = 16'h0037;
   always @(posedge clk) begin
      cx_q <= (cx_q >= per_x - 16'h0001) ? 16'h0000 : cx_q + 16'h0001;
      cy_q <= (cy_q >= per_y - 16'h0001) ? 16'h0000 : cy_q + 16'h0001;
   end
   assign pwm_x = cx_q < hi_x;
   assign pwm_y = cy_q < hi_y;
endmodule
`default_nettype wire

// File: test/tilt_pwm_compass_readout_tb.sv
// Self-checking bench for the compass readout with a PWM partner.
// Assumes 200-cycle PWM periods and shortened frame and strap counts.
`timescale 1ns/1ps
`default_nettype none
module tilt_pwm_compass_readout_tb;
   typedef struct packed {logic [15:0] hx; logic [15:0] hy; logic [7:0] ep; logic [7:0] er;} row_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic adc_valid = 1'b0;
   logic [1:0] adc_channel = 2'h0;
   logic [tilt_pkg::ADC_W-1:0] adc_data = '0;
   logic signed [tilt_pkg::AXIS_W-1:0] corr_x = 12'h01F;
   logic signed [tilt_pkg::AXIS_W-1:0] corr_y = 12'hFFB;
   logic signed [tilt_pkg::AXIS_W-1:0] corr_z = 12'h014;
   logic low_power_en = 1'b0;
   logic auto_strap_en = 1'b0;
   logic strap_request = 1'b0;
   logic [15:0] per_x = 16'h00C8;
   logic [15:0] hi_x = 16'h0064;
   logic [15:0] per_y = 16'h00C8;
   logic [15:0] hi_y = 16'h0064;
   logic tx, ty, strap_line, sensor_power, meas_done, strap_seen;
   logic [1:0] tilt_valid;
   logic signed [7:0] pitch_deg, roll_deg;
   logic [tilt_pkg::ADC_W-1:0] ref_level;
   logic signed [tilt_pkg::AXIS_W-1:0] axis_x, axis_y, axis_z;
   int failures = 0;
   int samples_checked = 0;
   int dones = 0;
   int pwr_on = 0;
   int flips = 0;
   int n0;
   row_t rows [3] = '{'{16'h0064, 16'h0064, 8'h00, 8'h00},
      '{16'h008C, 16'h003C, 8'h5A, 8'hA6}, '{16'h003C, 16'h008C, 8'hA6, 8'h5A}};
   tilt_pwm_compass_readout #(.PERIOD_MIN(180), .PERIOD_MAX(220), .SNAP_CYCLES(20), .FRAME_CYCLES(200),
      .STRAP_CYCLES(50)) tilt_pwm_compass_readout_inst (.clk, .rst_b, .tilt_x_pwm(tx), .tilt_y_pwm(ty),
      .adc_valid, .adc_channel, .adc_data, .corr_x, .corr_y, .corr_z, .low_power_en, .auto_strap_en,
      .strap_request, .strap_line, .sensor_power, .meas_done, .tilt_valid, .pitch_deg, .roll_deg,
      .ref_level, .axis_x, .axis_y, .axis_z);
   accel_pwm_model accel_pwm_model_inst (.clk, .per_x, .hi_x, .per_y, .hi_y, .pwm_x(tx), .pwm_y(ty));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Counters sample at the edge and are read at the falling edge, so no race
   always @(posedge clk) begin
      if (meas_done === 1'b1) dones++;
      if (sensor_power === 1'b1) pwr_on++;
      if (strap_line !== strap_seen) flips++;
      strap_seen = strap_line;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic adc(input logic [1:0] ch, input logic [9:0] d);
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_channel <= ch;
      adc_data <= d;
   endtask
   task automatic adc_all;
      adc(tilt_pkg::CH_REF, 10'h0FF);
      adc(tilt_pkg::CH_X, 10'h14B);
      adc(tilt_pkg::CH_Y, 10'h106);
      adc(tilt_pkg::CH_Z, 10'h0CD);
      @(posedge clk);
      adc_valid <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      cyc(30000);
      failures++;
      report_and_stop();
   end
   initial begin
      cyc(5);
      @(negedge clk);
      chk({12'h000, sensor_power, strap_line, tilt_valid}, 16'h0000);
      cyc(5);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk);
         hi_x <= rows[i].hx;
         hi_y <= rows[i].hy;
         cyc(600);
         @(negedge clk);
         chk({14'h0000, tilt_valid}, 16'h0003);
         chk({8'h00, pitch_deg}, {8'h00, rows[i].ep});
         chk({8'h00, roll_deg}, {8'h00, rows[i].er});
      end
      hi_x <= 16'h0078;
      cyc(600);
      @(negedge clk);
      chk(16'(pitch_deg >= 29 && pitch_deg <= 31), 16'h0001);
      hi_x <= 16'h008C;
      cyc(600);
      hi_x <= 16'h003C;
      per_x <= 16'h012C;
      cyc(1000);
      @(negedge clk);
      chk({14'h0000, tilt_valid}, 16'h0002);
      chk({8'h00, pitch_deg}, 16'h005A);
      per_x <= 16'h0096;
      cyc(1000);
      @(negedge clk);
      chk({14'h0000, tilt_valid}, 16'h0002);
      per_x <= 16'h00C8;
      cyc(600);
      @(negedge clk);
      chk({8'h00, pitch_deg}, 16'h00A6);
      adc_all();
      cyc(3);
      @(negedge clk);
      chk({6'h00, ref_level}, 16'h00FF);
      chk(axis_x, 16'h002D);
      chk(axis_y, 16'h000C);
      chk(axis_z, 16'hFFBA);
      @(posedge clk);
      low_power_en <= 1'b1;
      @(negedge clk);
      n0 = dones;
      repeat (60) begin
         adc_all();
         cyc(6);
      end
      @(negedge clk);
      chk(16'(dones - n0 >= 2 && dones - n0 <= 4), 16'h0001);
      n0 = pwr_on;
      cyc(1000);
      @(negedge clk);
      chk(16'(pwr_on - n0), 16'h0064);
      @(posedge clk);
      low_power_en <= 1'b0;
      strap_request <= 1'b1;
      @(posedge clk);
      strap_request <= 1'b0;
      @(negedge clk);
      chk({15'h0000, strap_line}, 16'h0001);
      // The request's own flip is counted after this point, then four automatic ones
      n0 = flips;
      @(posedge clk);
      auto_strap_en <= 1'b1;
      cyc(220);
      @(negedge clk);
      chk(16'(flips - n0), 16'h0005);
      // Reset in mid-run: strap line, validity and angles fall back
      @(posedge clk);
      auto_strap_en <= 1'b0;
      rst_b <= 1'b0;
      cyc(2);
      @(negedge clk);
      chk({8'h00, pitch_deg}, 16'h0000);
      chk({13'h0000, meas_done, strap_line, tilt_valid}, 16'h0000);
      @(posedge clk);
      rst_b <= 1'b1;
      cyc(5);
      report_and_stop();
   end
endmodule
`default_nettype wire
